// [port_ctrl_pkg.sv]
// constants and carriers for the receive dma gate and transmit control alias
// assumes a 32-bit classic wishbone slave on mclk
package port_ctrl_pkg;
    localparam logic [7:0]  rx_dma_event_control_off    = 8'h8C;    // receive dma event control
    localparam logic [7:0]  tx_global_control_alias_off = 8'hA0;    // transmit alias of global control
    localparam logic [7:0]  port_global_control_off     = 8'h44;    // full global control
    localparam logic [7:0]  rx_data_status_off          = 8'h80;    // receive data status
    localparam int          gate_bit                    = 0;        // gate position
    localparam int          tx_lo                       = 8;        // transmit field low bit
    localparam int          tx_hi                       = 12;       // transmit field high bit
    localparam int          rx_lo                       = 0;        // receive field low bit
    localparam int          rx_hi                       = 4;        // receive field high bit
    localparam int          tx_fsg_bit                  = 12;       // frame sync generator run
    localparam int          tx_sm_bit                   = 11;       // state machine run
    localparam int          tx_ser_bit                  = 10;       // serializer clear release
    localparam int          tx_hclk_bit                 = 9;        // high freq clock run
    localparam int          tx_bclk_bit                 = 8;        // bit clock run
    localparam logic [31:0] gate_mask                   = 32'h0000_0001; // writable gate bits
    localparam logic [31:0] tx_mask                     = 32'h0000_1F00; // alias writable bits
    localparam logic [31:0] glb_mask                    = 32'h0000_1F1F; // global writable bits
    localparam logic [31:0] reset_value                 = 32'h0000_0000; // all registers reset

    typedef struct packed {
        logic tx_framesync_gen_run;        // bit 12
        logic tx_state_machine_run;        // bit 11
        logic tx_serializer_clear_release; // bit 10
        logic tx_high_freq_clock_run;      // bit 9
        logic tx_bit_clock_run;            // bit 8
    } tx_ctrl_s;

    typedef struct packed {
        logic rx_framesync_gen_run;
        logic rx_state_machine_run;
        logic rx_serializer_clear_release;
        logic rx_high_freq_clock_run;
        logic rx_bit_clock_run;
    } rx_ctrl_s;
endpackage

// [masked_reg.sv]
// one 32-bit register whose writable bits are picked by a mask
// assumes synchronous reset copy from the top
`timescale 1ns/1ns
`default_nettype none
module masked_reg #(
    parameter logic [31:0] wmask = 32'h0000_0000,   // writable bits
    parameter logic [31:0] rval  = 32'h0000_0000    // reset value
) (
    input  wire logic        clk,   // system clock
    input  wire logic        rst_n, // synchronised reset
    input  wire logic        we,    // write strobe
    input  wire logic [31:0] wmsk,  // byte enable expanded
    input  wire logic [31:0] wdat,  // write data
    output logic      [31:0] q      // stored value
);
    logic [31:0] next_q; // next stored value

    // only masked bits change; reserved bits stay at reset value
    always_comb
    begin
        next_q = q;
        if (we)
        begin
            next_q = (q & ~(wmask & wmsk)) | (wdat & wmask & wmsk);
        end
    end

    // register stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= rval;
        else
            q <= next_q;
    end
endmodule
`default_nettype wire

// [rx_dma_gate_and_tx_reset_alias.sv]
// register bank: receive dma request gate and transmit-only global control alias
// assumes classic wishbone master, one clock mclk, receive event pulses from the receive path
// How it works
// - bit 0 set suppresses receive dma requests
// - gate register bits 31..1 read zero
// - reserved bit writes change nothing at all
// - alias write changes only bits 12..8
// - alias read returns whole global control
// - transmit resets change without touching receiver
// - bit 12 runs transmit frame sync generator
// - bit 11 runs transmit state machine
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module rx_dma_gate_and_tx_reset_alias (
    input  wire logic                    mclk,        // system clock 100 MHz
    input  wire logic                    arst_n,      // async reset, active low
    input  wire logic                    cyc_i,       // wishbone cycle
    input  wire logic                    stb_i,       // wishbone strobe
    input  wire logic                    we_i,        // wishbone write
    input  wire logic [7:0]              adr_i,       // byte address
    input  wire logic [3:0]              sel_i,       // byte enables
    input  wire logic [31:0]             dat_i,       // write data
    output logic      [31:0]             dat_o,       // read data, registered
    output logic                         ack_o,       // acknowledge
    output logic                         err_o,       // unmapped address
    input  wire logic                    rx_data_evt, // receive data ready pulse
    output logic                         rx_dma_req,  // receive dma request to dma controller
    output port_ctrl_pkg::tx_ctrl_s      tx_ctrl,     // transmit run controls
    output port_ctrl_pkg::rx_ctrl_s      rx_ctrl      // receive run controls
);
    logic        rst_meta;     // reset sync stage 1
    logic        rst_n;        // reset sync stage 2
    logic [31:0] gate_q;       // gate register
    logic [31:0] glb_q;        // global control
    logic [31:0] bmask;        // byte enables as bit mask
    logic        req;          // new bus request
    logic        hit_gate;     // gate register address
    logic        hit_alias;    // alias address
    logic        hit_glb;      // global address
    logic        hit_stat;     // status address
    logic        hit_any;      // mapped
    logic        wr_ok;        // write taken this cycle
    logic        stat_clr;     // status write-one-to-clear
    logic        rx_pend;      // receive data status flag
    logic        next_rx_pend; // next status flag
    logic        next_req_o;   // next dma request
    logic [31:0] next_dat;     // next read data
    logic        next_ack;     // next ack
    logic        next_err;     // next err
    logic [31:0] glb_wmask;    // global write mask for this access

    // reset released through two flops
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // decode; ack drops the cycle after it is given
    always_comb
    begin
        bmask     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        req       = cyc_i && stb_i && !ack_o && !err_o;
        hit_gate  = adr_i == port_ctrl_pkg::rx_dma_event_control_off;
        hit_alias = adr_i == port_ctrl_pkg::tx_global_control_alias_off;
        hit_glb   = adr_i == port_ctrl_pkg::port_global_control_off;
        hit_stat  = adr_i == port_ctrl_pkg::rx_data_status_off;
        hit_any   = hit_gate || hit_alias || hit_glb || hit_stat;
        wr_ok     = req && we_i && hit_any;
        stat_clr  = wr_ok && hit_stat && sel_i[0] && dat_i[0];
        // alias only opens transmit bits so receiver state is untouched
        glb_wmask = hit_alias ? (bmask & port_ctrl_pkg::tx_mask) : bmask;
    end

    // gate register: only bit 0 stored, reserved bits ignored and read zero
    masked_reg #(
        .wmask (port_ctrl_pkg::gate_mask),
        .rval  (port_ctrl_pkg::reset_value)
    ) u_gate (
        .clk   (mclk),
        .rst_n (rst_n),
        .we    (wr_ok && hit_gate),
        .wmsk  (bmask),
        .wdat  (dat_i),
        .q     (gate_q)
    );

    // one global control shared by direct and alias paths
    masked_reg #(
        .wmask (port_ctrl_pkg::glb_mask),
        .rval  (port_ctrl_pkg::reset_value)
    ) u_glb (
        .clk   (mclk),
        .rst_n (rst_n),
        .we    (wr_ok && (hit_alias || hit_glb)),
        .wmsk  (glb_wmask),
        .wdat  (dat_i),
        .q     (glb_q)
    );

    // status and request next values; set wins over clear
    always_comb
    begin
        next_rx_pend = rx_pend;
        if (stat_clr)
            next_rx_pend = 1'b0;
        if (rx_data_evt)
            next_rx_pend = 1'b1;
        // request pulse only while gate is clear
        next_req_o = rx_data_evt && !gate_q[port_ctrl_pkg::gate_bit];
    end

    // bus answer next values
    always_comb
    begin
        next_ack = 1'b0;
        next_err = 1'b0;
        next_dat = dat_o;
        if (req)
        begin
            if (!hit_any)
                next_err = 1'b1; // unmapped answers with err
            else
                next_ack = 1'b1;
            if (!we_i)
            begin
                if (hit_gate)
                    next_dat = gate_q;
                else if (hit_alias || hit_glb)
                    next_dat = glb_q;
                else if (hit_stat)
                    next_dat = {31'h0000_0000, rx_pend};
                else
                    next_dat = 32'h0000_0000;
            end
        end
    end

    // register stage for bus and dma side
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_o      <= 1'b0;
            err_o      <= 1'b0;
            dat_o      <= 32'h0000_0000;
            rx_pend    <= 1'b0;
            rx_dma_req <= 1'b0;
        end
        else if (!rst_n)
        begin
            ack_o      <= 1'b0;
            err_o      <= 1'b0;
            dat_o      <= 32'h0000_0000;
            rx_pend    <= 1'b0;
            rx_dma_req <= 1'b0;
        end
        else
        begin
            ack_o      <= next_ack;
            err_o      <= next_err;
            dat_o      <= next_dat;
            rx_pend    <= next_rx_pend;
            rx_dma_req <= next_req_o;
        end
    end

    // run controls straight from global control flops
    always_comb
    begin
        tx_ctrl.tx_framesync_gen_run        = glb_q[port_ctrl_pkg::tx_fsg_bit];
        tx_ctrl.tx_state_machine_run        = glb_q[port_ctrl_pkg::tx_sm_bit];
        tx_ctrl.tx_serializer_clear_release = glb_q[port_ctrl_pkg::tx_ser_bit];
        tx_ctrl.tx_high_freq_clock_run      = glb_q[port_ctrl_pkg::tx_hclk_bit];
        tx_ctrl.tx_bit_clock_run            = glb_q[port_ctrl_pkg::tx_bclk_bit];
        rx_ctrl                             = glb_q[port_ctrl_pkg::rx_hi:port_ctrl_pkg::rx_lo];
    end
endmodule
`default_nettype wire

// [port_ctrl_checker.sv]
// assertions on the gate and alias register bank ports
// assumes it is bound onto the bank top, one clock mclk
`timescale 1ns/1ns
`default_nettype none
module port_ctrl_checker (
    input wire logic                    mclk,        // clock
    input wire logic                    arst_n,      // reset
    input wire logic                    cyc_i,       // cycle
    input wire logic                    stb_i,       // strobe
    input wire logic                    we_i,        // write
    input wire logic [7:0]              adr_i,       // address
    input wire logic [3:0]              sel_i,       // lanes
    input wire logic [31:0]             dat_i,       // wdata
    input wire logic [31:0]             dat_o,       // rdata
    input wire logic                    ack_o,       // ack
    input wire logic                    err_o,       // error
    input wire logic                    rx_data_evt, // event
    input wire logic                    rx_dma_req,  // request
    input wire port_ctrl_pkg::tx_ctrl_s tx_ctrl,     // tx run
    input wire port_ctrl_pkg::rx_ctrl_s rx_ctrl      // rx run
);
    wire logic tk = cyc_i && stb_i && !ack_o && !err_o; // request taken
    wire logic wa = ack_o && we_i;                      // write lands
    wire logic ra = ack_o && !we_i;                     // read answered
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // every taken request gets exactly one answer next cycle
    ack_one_a: assert property (tk |=> ack_o ^ err_o)
        else $error("no single answer");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    map_err_a: assert property (tk && !(adr_i inside {8'h44, 8'h80, 8'h8C, 8'hA0}) |=> err_o)
        else $error("unmapped address not refused");
    gate_rsv_a: assert property (ra && adr_i == 8'h8C |-> dat_o[31:1] == 31'h0)
        else $error("gate reserved bits not zero");
    // alias read mirrors both fields of the live global register
    alias_rd_a: assert property (ra && adr_i == 8'hA0 |-> dat_o == {19'h0, tx_ctrl, 3'h0, rx_ctrl})
        else $error("alias read differs from global");
    alias_wr_a: assert property (wa && adr_i == 8'hA0 && sel_i[1] |=> tx_ctrl == $past(dat_i[12:8]))
        else $error("alias write not taken");
    // registers update on the taking edge, so the exemption keys on the taken write
    rx_keep_a: assert property (!(tk && we_i && adr_i == 8'h44) |=> $stable(rx_ctrl))
        else $error("receive controls disturbed");
    tx_keep_a: assert property (!(tk && we_i && adr_i inside {8'h44, 8'hA0}) |=> $stable(tx_ctrl))
        else $error("transmit controls changed without write");
    req_cause_a: assert property (rx_dma_req |-> $past(rx_data_evt))
        else $error("request without event");
endmodule
`default_nettype wire

// [dma_sink.sv]
// dma controller side: counts receive requests it is handed
// assumes one-cycle request pulses on the bank clock
`timescale 1ns/1ns
`default_nettype none
module dma_sink (
    input  wire logic mclk,  // clock
    input  wire logic req,   // request pulse
    output int        n_seen // pulses taken
);
    initial n_seen = 0;
    // one transfer per pulse, so a stretched pulse shows as extra
    always @(posedge mclk)
        if (req) n_seen <= n_seen + 1;
endmodule
`default_nettype wire

// [tb_rx_dma_gate_and_tx_reset_alias.sv]
// bench: random wishbone traffic and events against a behavioural model
// assumes the bank, its checker and the dma sink model
`timescale 1ns/1ns
`default_nettype none
module tb_rx_dma_gate_and_tx_reset_alias;
    logic mclk = 0, arst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, rx_data_evt = 0, ack_o, err_o, rx_dma_req;
    logic [7:0]  adr_i = 8'h00;       // address
    logic [3:0]  sel_i = 4'h0;        // lanes
    logic [31:0] dat_i = 32'h0, dat_o; // data
    port_ctrl_pkg::tx_ctrl_s tx_ctrl; // tx run
    port_ctrl_pkg::rx_ctrl_s rx_ctrl; // rx run
    int n_mismatch = 0, checked = 0, cyc_n = 0, n_seen, n_req = 0, seed = 32'h83B1;
    logic [7:0]  adrs [5] = '{8'h8C, 8'hA0, 8'h44, 8'h80, 8'h10}; // last is unmapped
    logic [31:0] glb = 32'h0, r, d, x, m; // model global register
    logic gate = 0, st = 0, e;            // model gate and status
    rx_dma_gate_and_tx_reset_alias i_rx_dma_gate_and_tx_reset_alias (.mclk, .arst_n, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .rx_data_evt, .rx_dma_req, .tx_ctrl, .rx_ctrl);
    dma_sink i_dma_sink (.mclk, .req(rx_dma_req), .n_seen);
    initial forever #5 mclk = ~mclk;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one classic cycle, held until ack or err is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
        @(posedge mclk);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, wd, s};
        do @(posedge mclk); while (!(ack_o | err_o) && cyc_n < 9000);
        r = dat_o;
        e = err_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h8C:        return {31'h0, gate};
            8'h80:        return {31'h0, st};
            8'h10:        return 32'h0; // refused read returns zero
            default:      return glb;
        endcase
    endfunction
    // hang guard, about eight thousand cycles above the planned run of under a thousand
    always @(posedge mclk)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 9000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        arst_n <= 1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 4; i++)
        begin
            wb(0, adrs[i], 32'h0, 4'hF);
            chk("reset value", r, 32'h0);
        end
        // well-behaved software: reserved bits written as zero
        wb(1, 8'h8C, 32'h0, 4'hF);
        chk("gate write err", e, 32'h0);
        // reserved bits get random data on purpose to prove they are ignored
        repeat (120)
        begin
            x = $random(seed);
            d = $random(seed);
            m = {{8{x[7]}}, {8{x[6]}}, {8{x[5]}}, {8{x[4]}}};
            wb(x[0], adrs[x[15:8] % 5], d, x[7:4]);
            chk("err", e, adr_i == 8'h10);
            if (!x[0]) chk("read", r, exp_rd(adr_i));
            else if (adr_i == 8'h8C && x[4]) gate = d[0];
            else if (adr_i == 8'hA0) glb = glb & ~(m & port_ctrl_pkg::tx_mask) | d & m & port_ctrl_pkg::tx_mask;
            else if (adr_i == 8'h44) glb = glb & ~(m & port_ctrl_pkg::glb_mask) | d & m & port_ctrl_pkg::glb_mask;
            else if (adr_i == 8'h80 && x[4] && d[0]) st = 0;
            @(posedge mclk);
            rx_data_evt <= x[1];
            @(posedge mclk);
            rx_data_evt <= 0;
            st = st | x[1];
            n_req += x[1] & !gate;
            @(posedge mclk);
            chk("dma request", rx_dma_req, x[1] & !gate);
            chk("tx controls", tx_ctrl, glb[12:8]);
            chk("rx controls", rx_ctrl, glb[4:0]);
        end
        chk("dma count", n_seen, n_req);
        test_done();
    end
endmodule
bind rx_dma_gate_and_tx_reset_alias port_ctrl_checker i_port_ctrl_checker (.mclk, .arst_n, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .rx_data_evt, .rx_dma_req, .tx_ctrl, .rx_ctrl);
`default_nettype wire
